// file: can_filter_defs.svh
`ifndef CAN_FILTER_DEFS_SVH
`define CAN_FILTER_DEFS_SVH

// ==========================================================
// Byte offsets inside the module's address space
`define FILT_ACC_BASE 6'h10
`define FILT_MASK_BASE 6'h18
`define FILT_BANK_END 6'h1f
`define RXWIN_BASE 6'h20
`define RXWIN_ID_BASE 6'h20
`define RXWIN_DATA_BASE 6'h24
`define RXWIN_DLC 6'h2c
`define RXWIN_STAMP_HI 6'h2e
`define RXWIN_STAMP_LO 6'h2f
`define RXWIN_END 6'h2f

// ==========================================================
// Reset values and defaults
`define FILT_RESET_VAL 8'h00
`define RX_DEPTH_DEF 4

`endif

// file: can_filter_pkg.sv
package can_filter_pkg;

    // ==========================================================
    // Frame as delivered by the receive shifter
    typedef struct packed {
        logic [31:0] id;
        logic [7:0][7:0] data;
        logic [3:0] dlc;
    } rx_frame_t;

    // One FIFO stage: frame plus its own time stamp
    typedef struct packed {
        rx_frame_t frame;
        logic [15:0] stamp;
    } rx_entry_t;

    // CPU byte access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cpu_req_t;

    // Filter bank as seen by the comparison logic
    typedef struct packed {
        logic [7:0][7:0] accept;
        logic [7:0][7:0] mask;
    } filter_bank_t;

endpackage : can_filter_pkg

// file: can_id_filter_rx_fifo.sv
// Function
// RULE1: Eight acceptance registers clear to zero on reset.
// RULE2: Acceptance registers read anytime; writes only when init request and acknowledge high.
// RULE3: Eight mask registers clear to zero on reset and read anytime.
// RULE4: Received messages queue in four-stage FIFO; oldest entry shown to CPU.
// RULE5: Each FIFO stage stores its own time stamp with its message.
// RULE6: Receive window at fixed offset holds identifier, data and length registers.
// RULE7: Window reads valid only while receive-full set; window not writable.
// RULE8: Mask writes gated by the same init-mode handshake as acceptance.
`include "can_filter_defs.svh"

module can_id_filter_rx_fifo #(
    parameter int DEPTH = `RX_DEPTH_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Init-mode handshake
    input wire logic init_mode_request,
    input wire logic init_mode_acknowledge,
    // CPU byte access
    input can_filter_pkg::cpu_req_t cpu_req,
    output can_filter_pkg::filter_bank_t filter_q,
    output logic [7:0] cpu_rdata_q,
    // Receive side
    input wire logic rx_valid,
    input can_filter_pkg::rx_frame_t rx_frame,
    input wire logic [15:0] time_stamp,
    input wire logic rx_release,
    output logic receive_full_flag_q,
    output logic rx_overrun_q
);
    import can_filter_pkg::*;

    localparam int PW = $clog2(DEPTH);

    // Refused at elaboration: the pointers wrap freely, so only a power of two works
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
        $error("DEPTH must be a power of two of at least 2");
    end

    // ==========================================================
    // Address decode helpers
    function automatic logic in_range(input logic [5:0] a, input logic [5:0] lo, input logic [5:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic [7:0] window_byte(input rx_entry_t e, input logic [5:0] a);
        logic [5:0] off;
        off = a - `RXWIN_BASE;
        window_byte = 8'h00;
        if (a < `RXWIN_DATA_BASE) begin
            window_byte = e.frame.id[8'(31 - 8 * off) -: 8];
        end else if (a < `RXWIN_DLC) begin
            window_byte = e.frame.data[3'(a - `RXWIN_DATA_BASE)];
        end else if (a == `RXWIN_DLC) begin
            window_byte = {4'h0, e.frame.dlc};
        end else if (a == `RXWIN_STAMP_HI) begin
            window_byte = e.stamp[15:8];
        end else if (a == `RXWIN_STAMP_LO) begin
            window_byte = e.stamp[7:0];
        end
    endfunction : window_byte

    // ==========================================================
    // Filter bank
    logic init_open;
    filter_bank_t filter_d;

    assign init_open = init_mode_request && init_mode_acknowledge;

    always_comb begin
        filter_d = filter_q;
        // Writes outside init mode are dropped silently, no error is flagged
        if (cpu_req.wr && init_open) begin //RULE2
            if (in_range(cpu_req.addr, `FILT_ACC_BASE, `FILT_MASK_BASE - 6'h01)) begin
                filter_d.accept[3'(cpu_req.addr - `FILT_ACC_BASE)] = cpu_req.wdata; //RULE2
            end else if (in_range(cpu_req.addr, `FILT_MASK_BASE, `FILT_BANK_END)) begin
                filter_d.mask[3'(cpu_req.addr - `FILT_MASK_BASE)] = cpu_req.wdata; //RULE8
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filter_q.accept <= {8{`FILT_RESET_VAL}}; //RULE1
            filter_q.mask <= {8{`FILT_RESET_VAL}}; //RULE3
        end else begin
            filter_q <= filter_d;
        end
    end

    // ==========================================================
    // Receive FIFO
    rx_entry_t stage_q [DEPTH];
    rx_entry_t stage_d [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [PW:0] count_q, count_d;
    logic overrun_d, full_d, push, pop;

    // A frame arriving while full is lost rather than overwriting the oldest
    assign push = rx_valid && (count_q != (PW+1)'(DEPTH));
    assign pop = rx_release && (count_q != '0);

    always_comb begin
        stage_d = stage_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        overrun_d = rx_valid && !push;
        if (push) begin
            stage_d[wr_ptr_q] = '{frame: rx_frame, stamp: time_stamp}; //RULE5
            wr_ptr_d = wr_ptr_q + PW'(1); //RULE4
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + PW'(1); //RULE4
        end
        count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
        full_d = (count_d != '0);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            receive_full_flag_q <= 1'b0;
            rx_overrun_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            receive_full_flag_q <= full_d;
            rx_overrun_q <= overrun_d;
        end
    end

    // ==========================================================
    // CPU read path, one cycle latency
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (cpu_req.rd) begin
            if (in_range(cpu_req.addr, `FILT_ACC_BASE, `FILT_MASK_BASE - 6'h01)) begin
                rdata_d = filter_q.accept[3'(cpu_req.addr - `FILT_ACC_BASE)]; //RULE2
            end else if (in_range(cpu_req.addr, `FILT_MASK_BASE, `FILT_BANK_END)) begin
                rdata_d = filter_q.mask[3'(cpu_req.addr - `FILT_MASK_BASE)]; //RULE3
            end else if (in_range(cpu_req.addr, `RXWIN_BASE, `RXWIN_END) && receive_full_flag_q) begin
                // Oldest entry only; empty window reads as zero
                rdata_d = window_byte(stage_q[rd_ptr_q], cpu_req.addr); //RULE6 RULE7
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata_q <= 8'h00;
        end else begin
            cpu_rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Assertions
    property p_acc_reset;
        @(posedge clock) disable iff (!rst_n) !$past(rst_n) |-> filter_q.accept == '0;
    endproperty
    a_acc_reset: assert property (p_acc_reset) else $error("acceptance not zero after reset"); //RULE1

    property p_acc_gated;
        @(posedge clock) disable iff (!rst_n) !init_open |=> $stable(filter_q.accept);
    endproperty
    a_acc_gated: assert property (p_acc_gated) else $error("acceptance changed outside init"); //RULE2

    property p_mask_reset;
        @(posedge clock) disable iff (!rst_n) !$past(rst_n) |-> filter_q.mask == '0;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not zero after reset"); //RULE3

    property p_mask_gated;
        @(posedge clock) disable iff (!rst_n) !init_open |=> $stable(filter_q.mask);
    endproperty
    a_mask_gated: assert property (p_mask_gated) else $error("mask changed outside init"); //RULE8

    property p_mask_read;
        @(posedge clock) disable iff (!rst_n)
            cpu_req.rd && cpu_req.addr == `FILT_MASK_BASE |=> cpu_rdata_q == $past(filter_q.mask[0]);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); //RULE3

    property p_fifo_bound;
        @(posedge clock) disable iff (!rst_n)
            count_q == (PW+1)'(DEPTH) && rx_valid && !rx_release |=> count_q == (PW+1)'(DEPTH) && rx_overrun_q;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("full FIFO accepted frame"); //RULE4

    property p_stamp_kept;
        @(posedge clock) disable iff (!rst_n)
            count_q == '0 && rx_valid && !rx_release |=> stage_q[rd_ptr_q].stamp == $past(time_stamp);
    endproperty
    a_stamp_kept: assert property (p_stamp_kept) else $error("stamp not stored with frame"); //RULE5

    property p_dlc_read;
        @(posedge clock) disable iff (!rst_n)
            cpu_req.rd && cpu_req.addr == `RXWIN_DLC && receive_full_flag_q
            |=> cpu_rdata_q == {4'h0, $past(stage_q[rd_ptr_q].frame.dlc)};
    endproperty
    a_dlc_read: assert property (p_dlc_read) else $error("window length byte wrong"); //RULE6

    property p_empty_window;
        @(posedge clock) disable iff (!rst_n)
            cpu_req.rd && in_range(cpu_req.addr, `RXWIN_BASE, `RXWIN_END) && !receive_full_flag_q
            |=> cpu_rdata_q == 8'h00;
    endproperty
    a_empty_window: assert property (p_empty_window) else $error("empty window returned data"); //RULE7

    c_fill: cover property (@(posedge clock) disable iff (!rst_n) count_q == (PW+1)'(DEPTH));
    c_overrun: cover property (@(posedge clock) disable iff (!rst_n) rx_overrun_q);
    c_init_write: cover property (@(posedge clock) disable iff (!rst_n) cpu_req.wr && init_open);
    c_push_pop: cover property (@(posedge clock) disable iff (!rst_n) push && pop);

endmodule : can_id_filter_rx_fifo

// file: can_rx_source_model.sv
module can_rx_source_model
    import can_filter_pkg::*;
(
    // Clock
    input wire logic clock,
    // Frame offer
    output logic rx_valid,
    output can_filter_pkg::rx_frame_t rx_frame,
    output logic [15:0] time_stamp
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        rx_valid = 1'b0;
        rx_frame = '0;
        time_stamp = 16'h0000;
    end

    // Chained calls give one frame per edge
    task automatic push(input rx_frame_t f, input logic [15:0] s);
        @(posedge clock);
        #1;
        rx_valid = 1'b1;
        rx_frame = f;
        time_stamp = s;
    endtask : push

    // Lines scrambled between frames so stale values never pass for fresh ones
    task automatic idle();
        @(posedge clock);
        #1;
        rx_valid = 1'b0;
        rx_frame = ~rx_frame;
        time_stamp = ~time_stamp;
    endtask : idle
endmodule : can_rx_source_model

// file: test_can_id_filter_rx_fifo.sv
module test_can_id_filter_rx_fifo
    import can_filter_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic init_mode_request = 1'b0;
    logic init_mode_acknowledge = 1'b0;
    cpu_req_t cpu_req = '0;
    filter_bank_t filter_q;
    logic [7:0] cpu_rdata_q;
    logic rx_valid;
    rx_frame_t rx_frame;
    logic [15:0] time_stamp;
    logic rx_release = 1'b0;
    logic receive_full_flag_q;
    logic rx_overrun_q;
    int fails = 0;
    int checked = 0;

    // ==========================================================
    // Design and frame source
    can_id_filter_rx_fifo #(.DEPTH(4)) uut (.clock(clock), .rst_n(rst_n),
        .init_mode_request(init_mode_request), .init_mode_acknowledge(init_mode_acknowledge),
        .cpu_req(cpu_req), .filter_q(filter_q), .cpu_rdata_q(cpu_rdata_q), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .time_stamp(time_stamp), .rx_release(rx_release),
        .receive_full_flag_q(receive_full_flag_q), .rx_overrun_q(rx_overrun_q));
    can_rx_source_model src (.clock(clock), .rx_valid(rx_valid), .rx_frame(rx_frame),
        .time_stamp(time_stamp));

    always #2.5 clock = ~clock;

    // ==========================================================
    // Helpers
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clock);
        #1;
        cpu_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge clock);
        #1;
        cpu_req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        cpu_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1;
        d = cpu_rdata_q;
        cpu_req.rd = 1'b0;
    endtask : rd

    task automatic pop();
        @(posedge clock);
        #1;
        rx_release = 1'b1;
        @(posedge clock);
        #1;
        rx_release = 1'b0;
    endtask : pop

    function automatic rx_frame_t mkf(input int i);
        rx_frame_t f;
        f.id = 32'h1a2b3c40 + 32'(i);
        for (int k = 0; k < 8; k++) f.data[k] = 8'(16 * i + k + 1);
        f.dlc = 4'(i + 5);
        return f;
    endfunction : mkf

    function automatic logic [15:0] stp(input int i);
        return 16'(16'h0a00 + 16'h0111 * i);
    endfunction : stp

    // Window byte at offset o from 0x20
    function automatic logic [7:0] expb(input rx_frame_t f, input logic [15:0] s, input int o);
        if (o < 4) return f.id[31 - 8 * o -: 8];
        if (o < 12) return f.data[o - 4];
        if (o == 12) return {4'h0, f.dlc};
        if (o == 13) return 8'h00;
        if (o == 14) return s[15:8];
        return s[7:0];
    endfunction : expb

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] d;
        chk("accept bank", 64'h0, filter_q.accept);
        chk("mask bank", 64'h0, filter_q.mask);
        for (int o = 0; o < 16; o++) begin
            rd(6'(16 + o), d);
            chk("filter read", 64'h0, 64'(d));
        end
        $display("test reset done");
    endtask : t_reset

    // Only request and acknowledge both high may open the bank
    task automatic t_gate();
        logic [7:0] d;
        for (int m = 0; m < 4; m++) begin
            init_mode_request = m[0];
            init_mode_acknowledge = m[1];
            wr(6'h12, 8'(8'ha0 + m));
            wr(6'h1d, 8'(8'hc0 + m));
            init_mode_request = 1'b0;
            init_mode_acknowledge = 1'b0;
            chk("accept byte", (m == 3) ? 64'ha3 : 64'h0, 64'(filter_q.accept[2]));
            chk("mask byte", (m == 3) ? 64'hc3 : 64'h0, 64'(filter_q.mask[5]));
            rd(6'h12, d);
            chk("accept read", (m == 3) ? 64'ha3 : 64'h0, 64'(d));
            rd(6'h1d, d);
            chk("mask read", (m == 3) ? 64'hc3 : 64'h0, 64'(d));
        end
        $display("test gate done");
    endtask : t_gate

    // Reset in mid-run must clear what software wrote and drop queued frames
    task automatic t_midreset();
        logic [7:0] d;
        src.push(mkf(7), stp(7));
        src.idle();
        chk("full flag", 64'h1, 64'(receive_full_flag_q));
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk("accept bank", 64'h0, filter_q.accept);
        chk("mask bank", 64'h0, filter_q.mask);
        chk("full flag", 64'h0, 64'(receive_full_flag_q));
        rd(6'h20, d);
        chk("empty window", 64'h0, 64'(d));
        pop();
        chk("full flag", 64'h0, 64'(receive_full_flag_q));
        $display("test midreset done");
    endtask : t_midreset

    task automatic t_fifo();
        logic [7:0] d;
        rd(6'h20, d);
        chk("empty window", 64'h0, 64'(d));
        for (int i = 0; i < 5; i++) src.push(mkf(i), stp(i));
        src.idle();
        chk("overrun", 64'h1, 64'(rx_overrun_q));
        chk("full flag", 64'h1, 64'(receive_full_flag_q));
        wr(6'h20, 8'hff);
        for (int i = 0; i < 4; i++) begin
            for (int o = 0; o < 16; o++) begin
                rd(6'(32 + o), d);
                chk("window byte", 64'(expb(mkf(i), stp(i), o)), 64'(d));
            end
            pop();
        end
        chk("full flag", 64'h0, 64'(receive_full_flag_q));
        chk("overrun", 64'h0, 64'(rx_overrun_q));
        $display("test fifo done");
    endtask : t_fifo

    // ==========================================================
    // Verdict
    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        #20000;
        fails++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_gate();
        t_midreset();
        t_fifo();
        test_done();
    end
endmodule : test_can_id_filter_rx_fifo
